// *** src/ahm_irq_tracker.sv ***
// one pending flag per interrupt identifier
// assumes issue and answer strobes are single-cycle and synchronous
`timescale 1ns/10ps
`default_nettype none
module ahm_irq_tracker
    import ahm_pkg::*;
(
    // clock and reset
    input  wire logic                ref_clk_in,
    input  wire logic                srst_in,
    // issue and answer
    input  wire logic                issue_in,
    input  wire logic [IRQ_ID_W-1:0] issue_id_in,
    input  wire logic                answer_in,
    input  wire logic [IRQ_ID_W-1:0] answer_id_in,
    // state
    output logic      [IRQ_IDS-1:0]  pending_out
);

    // ************************************************************
    // per-identifier flags
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < IRQ_IDS; g++)
        begin : g_id
            wire set_w = issue_in && (issue_id_in == g);
            wire clr_w = answer_in && (answer_id_in == g);
            always_ff @(posedge ref_clk_in)
            begin
                if (srst_in)
                    pending_out[g] <= 1'b0;
                else if (set_w)
                    pending_out[g] <= 1'b1;
                else if (clr_w)
                    pending_out[g] <= 1'b0;
            end
        end
    endgenerate

    // ************************************************************
    // checks
    // ************************************************************
    property p_no_reissue;
        @(posedge ref_clk_in) disable iff (srst_in)
        issue_in |-> !pending_out[issue_id_in];
    endproperty
    a_no_reissue: assert property (p_no_reissue)
        else $error("interrupt reissued before its answer");

endmodule // ahm_irq_tracker
`default_nettype wire

// *** src/ahm_mem_port_client.sv ***
// accelerator-side client of the host memory port, driven by software
// assumes an ahb-lite master on the register side and the port on the
// other side, both synchronous to ref_clk_in
//
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module ahm_mem_port_client
    import ahm_pkg::*;
(
    // clock and reset
    input  wire logic                ref_clk_in,
    input  wire logic                srst_in,
    // ahb-lite slave
    input  wire logic                hsel_in,
    input  wire logic [31:0]         haddr_in,
    input  wire logic [1:0]          htrans_in,
    input  wire logic                hwrite_in,
    input  wire logic [2:0]          hsize_in,
    input  wire logic [31:0]         hwdata_in,
    input  wire logic                hready_in,
    output logic                     hreadyout_out,
    output logic                     hresp_out,
    output logic      [31:0]         hrdata_out,
    // port control inputs
    input  wire logic                port_soft_reset_in,
    input  wire logic [1:0]          accel_power_state_in,
    input  wire logic                protocol_error_flag_in,
    // transmit channel 0, reads
    output logic                     tx0_valid_out,
    output logic      [TYPE_W-1:0]   tx0_req_type_out,
    output logic      [ADDR_W-1:0]   tx0_addr_out,
    output logic      [MDATA_W-1:0]  tx0_mdata_out,
    input  wire logic                tx0_almost_full_in,
    // receive channel 0
    input  wire logic                rx0_resp_valid_in,
    input  wire logic [TYPE_W-1:0]   rx0_resp_type_in,
    input  wire logic [MDATA_W-1:0]  rx0_mdata_in,
    input  wire logic [LINE_W-1:0]   rx0_data_in,
    // transmit channel 1, writes, fences, interrupts
    output logic                     tx1_valid_out,
    output logic      [TYPE_W-1:0]   tx1_req_type_out,
    output logic                     tx1_mode_out,
    output logic      [ADDR_W-1:0]   tx1_addr_out,
    output logic      [MDATA_W-1:0]  tx1_mdata_out,
    output logic      [LINE_W-1:0]   tx1_data_out,
    input  wire logic                tx1_almost_full_in,
    // receive channel 1
    input  wire logic                rx1_resp_valid_in,
    input  wire logic [TYPE_W-1:0]   rx1_resp_type_in,
    input  wire logic [MDATA_W-1:0]  rx1_mdata_in
);

    // ************************************************************
    // declarations
    // ************************************************************
    ahm_state_t           state_r, state_nxt;
    logic                 wr_pend_r;
    logic [7:0]           wr_ofs_r;
    logic [3:0]           cfg_r;
    logic [31:0]          addr_lo_r;
    logic [9:0]           addr_hi_r;
    logic [31:0]          wdata_r;
    logic [1:0]           op_r;
    logic [IRQ_ID_W-1:0]  irq_id_r;
    logic [MDATA_W-1:0]   tag_r;
    logic [MDATA_W-1:0]   sent_tag_r;
    logic [3:0]           done_r;
    logic                 unsolicited_message_r;
    logic                 err_r;
    logic [31:0]          rdata_r;
    logic [MDATA_W-1:0]   rtag_r;
    logic [IRQ_IDS-1:0]   irq_pend;

    // ************************************************************
    // bus decode
    // ************************************************************
    // writes take one wait state so a following read sees new data
    wire       addr_ph   = hsel_in && htrans_in[1] && hready_in
                           && (haddr_in[31:18] == 14'h0000);
    wire       rd_ph     = addr_ph && !hwrite_in;
    wire       wr_ph     = addr_ph && hwrite_in;
    wire [7:0] rd_ofs    = haddr_in[7:0];
    wire       wr_fire   = wr_pend_r;
    wire       chan_rst  = srst_in || port_soft_reset_in;
    wire       cmd_go    = wr_fire && (wr_ofs_r == OFS_CMD)
                           && (state_r == ST_IDLE) && !port_soft_reset_in;
    wire       clr_sts   = wr_fire && (wr_ofs_r == OFS_STATUS);
    wire [31:0] status_w = {18'h0, accel_power_state_in,
                            port_soft_reset_in, err_r, irq_pend,
                            unsolicited_message_r, done_r, (state_r != ST_IDLE)};
    wire [31:0] rd_mux =
        (rd_ofs == OFS_CFG)     ? {28'h0, cfg_r}     :
        (rd_ofs == OFS_ADDR_LO) ? addr_lo_r          :
        (rd_ofs == OFS_ADDR_HI) ? {22'h0, addr_hi_r} :
        (rd_ofs == OFS_WDATA)   ? wdata_r            :
        (rd_ofs == OFS_STATUS)  ? status_w           :
        (rd_ofs == OFS_RDATA)   ? rdata_r            :
        (rd_ofs == OFS_RTAG)    ? {16'h0, rtag_r}    : RST_WORD;

    // ************************************************************
    // request formation
    // ************************************************************
    wire [ADDR_W-1:0] mem_addr = {addr_hi_r, addr_lo_r};
    wire [3:0] rd_type = cfg_r[CFG_RD_SHARED] ? REQ_READ_SHARED_CACHE
                                              : REQ_READ_NO_CACHE;
    wire [1:0] wr_hint = cfg_r[CFG_WR_HINT +: 2];
    wire [3:0] wr_type = (wr_hint == 2'h1) ? REQ_WRITE_KEEP_MODIFIED :
                         (wr_hint == 2'h2) ? REQ_WRITE_PUSH_CPU
                                           : REQ_WRITE_NO_CACHE;
    wire       wr_mode = cfg_r[CFG_WR_BYTE] ? WRITE_MODE_BYTE_ENABLE
                                            : WRITE_MODE_FULL_LINE;
    wire [3:0] c1_type = (op_r == OP_FENCE) ? REQ_WRITE_FENCE :
                         (op_r == OP_INTR)  ? REQ_INTR : wr_type;
    wire [MDATA_W-1:0] c1_tag = (op_r == OP_INTR)
                         ? {tag_r[MDATA_W-1:IRQ_ID_W], irq_id_r} : tag_r;
    // reads go out on tx0 and other ops on tx1, each only when its own channel has room
    wire go_c0 = (state_r == ST_ISSUE) && (op_r == OP_READ)
                 && !tx0_almost_full_in;
    wire go_c1 = (state_r == ST_ISSUE) && (op_r != OP_READ)
                 && !tx1_almost_full_in
                 && !((op_r == OP_INTR) && irq_pend[irq_id_r]);

    // ************************************************************
    // response matching
    // ************************************************************
    // only the defined fields are decoded; reserved bits never looked at
    wire rx0_read = rx0_resp_valid_in
                    && (rx0_resp_type_in == RSP_MEM_READ);
    wire rx0_unsolicited_message = rx0_resp_valid_in
                    && (rx0_resp_type_in == RSP_UNSOLICITED);
    wire rd_match = rx0_read && (rx0_mdata_in == sent_tag_r);
    wire rx1_wr   = rx1_resp_valid_in && (rx1_resp_type_in == RSP_MEM_WRITE);
    wire rx1_fn   = rx1_resp_valid_in && (rx1_resp_type_in == RSP_FENCE);
    wire rx1_ir   = rx1_resp_valid_in
                    && (rx1_resp_type_in == RSP_INTR);
    wire c1_match = rx1_resp_valid_in
                    && (rx1_mdata_in == sent_tag_r)
                    && (((op_r == OP_WRITE) && rx1_wr)
                     || ((op_r == OP_FENCE) && rx1_fn));
    wire rsp_done = (state_r == ST_WAIT)
                    && ((op_r == OP_READ) ? rd_match : c1_match);
    wire [3:0] done_set = {rx1_ir,
                           rsp_done && (op_r == OP_FENCE),
                           rsp_done && (op_r == OP_WRITE),
                           rsp_done && (op_r == OP_READ)};

    // ************************************************************
    // sequencer
    // ************************************************************
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
                if (cmd_go)
                    state_nxt = ST_ISSUE;
            ST_ISSUE:
                if (go_c0 || (go_c1 && (op_r != OP_INTR)))
                    state_nxt = ST_WAIT;
                else if (go_c1)
                    state_nxt = ST_IDLE; // interrupts are posted
            ST_WAIT:
                if (rsp_done)
                    state_nxt = ST_IDLE;
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (chan_rst)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // ************************************************************
    // bus slave and software registers
    // ************************************************************
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            wr_pend_r     <= 1'b0;
            wr_ofs_r      <= 8'h00;
            hreadyout_out <= 1'b1;
            hrdata_out    <= RST_WORD;
        end
        else
        begin
            wr_pend_r     <= wr_ph;
            hreadyout_out <= !wr_ph;
            if (wr_ph)
                wr_ofs_r <= haddr_in[7:0];
            if (rd_ph)
                hrdata_out <= rd_mux;
        end
    end
    assign hresp_out = 1'b0;

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            cfg_r     <= 4'h0;
            addr_lo_r <= RST_WORD;
            addr_hi_r <= 10'h000;
            wdata_r   <= RST_WORD;
            op_r      <= OP_READ;
            irq_id_r  <= '0;
        end
        else if (wr_fire)
        begin
            if (wr_ofs_r == OFS_CFG)
                cfg_r <= hwdata_in[3:0];
            if (wr_ofs_r == OFS_ADDR_LO)
                addr_lo_r <= hwdata_in;
            if (wr_ofs_r == OFS_ADDR_HI)
                addr_hi_r <= hwdata_in[9:0];
            if (wr_ofs_r == OFS_WDATA)
                wdata_r <= hwdata_in;
            if (cmd_go)
            begin
                op_r     <= hwdata_in[CMD_OP +: 2];
                irq_id_r <= hwdata_in[CMD_IRQ_ID +: IRQ_ID_W];
            end
        end
    end

    // sticky status: a set in the clearing cycle wins
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            done_r  <= 4'h0;
            unsolicited_message_r  <= 1'b0;
            err_r   <= 1'b0;
            rdata_r <= RST_WORD;
            rtag_r  <= '0;
        end
        else
        begin
            done_r <= (done_r & ~(clr_sts ? hwdata_in[4:1] : 4'h0))
                      | done_set;
            unsolicited_message_r <= (unsolicited_message_r && !(clr_sts && hwdata_in[ST_UNSOLICITED_MESSAGE]))
                      || rx0_unsolicited_message;
            err_r  <= err_r || protocol_error_flag_in;
            if (rd_match && (state_r == ST_WAIT))
            begin
                rdata_r <= rx0_data_in[31:0];
                rtag_r  <= rx0_mdata_in;
            end
        end
    end

    // ************************************************************
    // transmit registers
    // ************************************************************
    // headers hold between requests; only valid marks a request
    always_ff @(posedge ref_clk_in)
    begin
        if (chan_rst)
        begin
            tx0_valid_out    <= 1'b0;
            tx0_req_type_out <= '0;
            tx0_addr_out     <= '0;
            tx0_mdata_out    <= '0;
            tx1_valid_out    <= 1'b0;
            tx1_req_type_out <= '0;
            tx1_mode_out     <= WRITE_MODE_FULL_LINE;
            tx1_addr_out     <= '0;
            tx1_mdata_out    <= '0;
            tx1_data_out     <= '0;
            tag_r            <= '0;
            sent_tag_r       <= '0;
        end
        else
        begin
            tx0_valid_out <= go_c0;
            tx1_valid_out <= go_c1;
            if (go_c0)
            begin
                tx0_req_type_out <= rd_type;
                tx0_addr_out     <= mem_addr;
                tx0_mdata_out    <= tag_r;
                sent_tag_r       <= tag_r;
                tag_r            <= tag_r + 1'b1;
            end
            if (go_c1)
            begin
                tx1_req_type_out <= c1_type;
                tx1_mode_out     <= wr_mode;
                tx1_mdata_out    <= c1_tag;
                sent_tag_r       <= c1_tag;
                tag_r            <= tag_r + 1'b1;
                // fences and interrupts carry no address or payload
                tx1_addr_out <= (op_r == OP_WRITE) ? mem_addr
                                                   : '0;
                tx1_data_out <= (op_r == OP_WRITE)
                                ? {480'h0, wdata_r} : '0;
            end
        end
    end

    ahm_irq_tracker u_irq_tracker (
        .ref_clk_in   (ref_clk_in),
        .srst_in      (chan_rst),
        .issue_in     (go_c1 && (op_r == OP_INTR)),
        .issue_id_in  (irq_id_r),
        .answer_in    (rx1_ir),
        .answer_id_in (rx1_mdata_in[IRQ_ID_W-1:0]),
        .pending_out  (irq_pend)
    );

    // ************************************************************
    // checks
    // ************************************************************
    // active-high reset keeps the plain name, no low suffix
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (chan_rst);

    property p_tx0_single;
        tx0_valid_out |=> !tx0_valid_out;
    endproperty
    a_tx0_single: assert property (p_tx0_single)
        else $error("read request held longer than one cycle");

    property p_tx0_flow;
        tx0_valid_out |-> !$past(tx0_almost_full_in);
    endproperty
    a_tx0_flow: assert property (p_tx0_flow)
        else $error("read sent while channel 0 almost full");

    property p_tx1_flow;
        tx1_valid_out |-> !$past(tx1_almost_full_in);
    endproperty
    a_tx1_flow: assert property (p_tx1_flow)
        else $error("write sent while channel 1 almost full");

    property p_rd_hint;
        tx0_valid_out |-> tx0_req_type_out ==
            ($past(cfg_r[CFG_RD_SHARED]) ? REQ_READ_SHARED_CACHE
                                         : REQ_READ_NO_CACHE);
    endproperty
    a_rd_hint: assert property (p_rd_hint)
        else $error("read hint does not follow configuration");

    property p_fence_empty;
        tx1_valid_out && (tx1_req_type_out == REQ_WRITE_FENCE)
            |-> (tx1_addr_out == '0) && (tx1_data_out == '0);
    endproperty
    a_fence_empty: assert property (p_fence_empty)
        else $error("fence carries address or data");

    property p_reserved_zero;
        tx1_valid_out |-> (tx1_data_out[LINE_W-1:32] == '0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved data bits not zero");

    property p_rd_addr;
        tx0_valid_out |-> tx0_addr_out == $past(mem_addr);
    endproperty
    a_rd_addr: assert property (p_rd_addr)
        else $error("read address differs from programmed one");

    property p_rd_pair;
        (state_r == ST_WAIT) && (op_r == OP_READ) && rx0_read
            && (rx0_mdata_in != sent_tag_r) |=> (state_r == ST_WAIT);
    endproperty
    a_rd_pair: assert property (p_rd_pair)
        else $error("read completed on a foreign tag");

    property p_wr_type;
        tx1_valid_out && ($past(op_r) == OP_WRITE)
            |-> (tx1_req_type_out == $past(wr_type))
                && (tx1_mode_out == $past(wr_mode));
    endproperty
    a_wr_type: assert property (p_wr_type)
        else $error("write type or mode does not follow configuration");

    c_read:  cover property (tx0_valid_out ##[1:50] done_r[0]);
    c_fence: cover property (tx1_valid_out ##[1:50] done_r[2]);
    c_intr:  cover property (tx1_valid_out && tx1_req_type_out == REQ_INTR);

endmodule // ahm_mem_port_client
`default_nettype wire

// *** src/ahm_pkg.sv ***
// constants, codes and register map for the memory port client
// assumes one 20 MHz clock; the device port is synchronous to it
package ahm_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int ADDR_W   = 42;
    localparam int MDATA_W  = 16;
    localparam int TYPE_W   = 4;
    localparam int LINE_W   = 512;
    localparam int IRQ_IDS  = 4;
    localparam int IRQ_ID_W = 2;

    // ************************************************************
    // request and response codes
    // ************************************************************
    localparam logic [3:0] REQ_READ_NO_CACHE       = 4'h0;
    localparam logic [3:0] REQ_READ_SHARED_CACHE   = 4'h1;
    localparam logic [3:0] REQ_WRITE_NO_CACHE      = 4'h0;
    localparam logic [3:0] REQ_WRITE_KEEP_MODIFIED = 4'h1;
    localparam logic [3:0] REQ_WRITE_PUSH_CPU      = 4'h2;
    localparam logic [3:0] REQ_WRITE_FENCE         = 4'h4;
    localparam logic [3:0] REQ_INTR                = 4'h6;
    localparam logic [3:0] RSP_MEM_READ            = 4'h0;
    localparam logic [3:0] RSP_UNSOLICITED         = 4'h4;
    localparam logic [3:0] RSP_MEM_WRITE           = 4'h0;
    localparam logic [3:0] RSP_FENCE               = 4'h4;
    localparam logic [3:0] RSP_INTR                = 4'h6;
    localparam logic       WRITE_MODE_FULL_LINE    = 1'b0;
    localparam logic       WRITE_MODE_BYTE_ENABLE  = 1'b1;

    // ************************************************************
    // register map (byte offsets) and reset values
    // ************************************************************
    localparam logic [7:0]  OFS_CFG     = 8'h00;
    localparam logic [7:0]  OFS_ADDR_LO = 8'h04;
    localparam logic [7:0]  OFS_ADDR_HI = 8'h08;
    localparam logic [7:0]  OFS_WDATA   = 8'h0c;
    localparam logic [7:0]  OFS_CMD     = 8'h10;
    localparam logic [7:0]  OFS_STATUS  = 8'h14;
    localparam logic [7:0]  OFS_RDATA   = 8'h18;
    localparam logic [7:0]  OFS_RTAG    = 8'h1c;
    localparam logic [31:0] RST_WORD    = 32'h0000_0000;

    // cfg fields
    localparam int CFG_RD_SHARED = 0;
    localparam int CFG_WR_HINT   = 1;   // two bits
    localparam int CFG_WR_BYTE   = 3;
    // cmd fields
    localparam int CMD_OP        = 0;   // two bits
    localparam int CMD_IRQ_ID    = 8;   // two bits
    localparam logic [1:0] OP_READ  = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_FENCE = 2'h2;
    localparam logic [1:0] OP_INTR  = 2'h3;
    // status fields, bits 1..5 are sticky, write one to clear
    localparam int ST_BUSY    = 0;
    localparam int ST_RD_DONE = 1;
    localparam int ST_WR_DONE = 2;
    localparam int ST_FN_DONE = 3;
    localparam int ST_IR_DONE = 4;
    localparam int ST_UNSOLICITED_MESSAGE    = 5;
    localparam int ST_IRQ_PND = 6;  // four bits
    localparam int ST_ERR     = 10;
    localparam int ST_SRST    = 11;
    localparam int ST_PWR     = 12; // two bits

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ISSUE = 3'b010,
        ST_WAIT  = 3'b100
    } ahm_state_t;

endpackage

// *** test/accel_host_memory_port_tb.sv ***
// bench: ahb master runs every command against the port model
// assumes the client and the port model above
`timescale 1ns/10ps
`default_nettype none
module accel_host_memory_port_tb;
    import ahm_pkg::*;
    logic               clk = 0, srst = 1, hsel = 0, hwrite = 0, st = 0;
    logic               hrdy, af, t0v, t1v, r0v, r1v;
    logic               psr = 0, um = 0, t1md;
    logic [1:0]         htrans = 0;
    logic [31:0]        haddr = 0, hwdata = 0, hrdata, q, e, x = 32'h8a86;
    logic [TYPE_W-1:0]  t0t, t1t, r1t, r0t;
    logic [ADDR_W-1:0]  t0a, t1a;
    logic [MDATA_W-1:0] t0m, t1m, r0m, r1m;
    logic [LINE_W-1:0]  r0d, t1d;
    int                 n_fail = 0, cmp_count = 0, k, op;
    wire [TYPE_W-1:0]   wt = e[2:1] == 2'h1 ? REQ_WRITE_KEEP_MODIFIED :
                             e[2:1] == 2'h2 ? REQ_WRITE_PUSH_CPU
                                            : REQ_WRITE_NO_CACHE;
    wire [TYPE_W-1:0]   c1t = op == 1 ? wt : op == 2 ? REQ_WRITE_FENCE
                                                     : REQ_INTR;
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    always #25 clk = ~clk;
    always @(posedge clk)
    begin
        x <= xs(x);
        st <= x[2];
    end
    ahm_mem_port_client u_ahm_mem_port_client (
        .ref_clk_in(clk), .srst_in(srst), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hready_in(hrdy), .hreadyout_out(hrdy),
        .hresp_out(), .hrdata_out(hrdata), .port_soft_reset_in(psr),
        .accel_power_state_in(2'h1), .protocol_error_flag_in(1'b0),
        .tx0_valid_out(t0v), .tx0_req_type_out(t0t), .tx0_addr_out(t0a),
        .tx0_mdata_out(t0m), .tx0_almost_full_in(af),
        .rx0_resp_valid_in(r0v), .rx0_resp_type_in(r0t),
        .rx0_mdata_in(r0m), .rx0_data_in(r0d), .tx1_valid_out(t1v),
        .tx1_req_type_out(t1t), .tx1_mode_out(t1md), .tx1_addr_out(t1a),
        .tx1_mdata_out(t1m), .tx1_data_out(t1d), .tx1_almost_full_in(af),
        .rx1_resp_valid_in(r1v), .rx1_resp_type_in(r1t), .rx1_mdata_in(r1m));
    ahm_port_model u_ahm_port_model (
        .clk_in(clk), .srst_in(srst), .stall_in(st), .um_in(um),
        .v0_in(t0v), .r0t_out(r0t),
        .a0_in(t0a), .m0_in(t0m), .v1_in(t1v), .t1_in(t1t), .m1_in(t1m),
        .af_out(af), .r0v_out(r0v), .r0m_out(r0m), .r0d_out(r0d),
        .r1v_out(r1v), .r1t_out(r1t), .r1m_out(r1m));
    task bus(input logic [7:0] a, input logic [31:0] d, input logic w);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        q = hrdata;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] ex);
        cmp_count++;
        if (s !== ex)
        begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, ex);
        end
    endtask
    task tally_and_finish;
        if (n_fail == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // request headers checked in the cycle their valid stands
    always @(posedge clk)
    begin
        if (t0v === 1'b1)
        begin
            chk(t0a[31:0], e);
            chk(t0t, e[0] ? REQ_READ_SHARED_CACHE : REQ_READ_NO_CACHE);
        end
        if (t1v === 1'b1)
        begin
            chk(t1t, c1t);
            chk(t1a[31:0], op == 1 ? e : 0);
            chk(t1d[31:0], op == 1 ? ~e : 0);
            chk({31'h0, |t1d[LINE_W-1:32]}, 0);
            if (op == 1)
                chk(t1md, e[3]);
            if (op == 3)
                chk(t1m[1:0], e[9:8]);
        end
    end
    initial
    begin
        #400000;
        n_fail++;
        tally_and_finish;
    end
    initial
    begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        bus(OFS_STATUS, 0, 0);
        chk(q & 32'h3001, 32'h1000);
        bus(8'h40, 0, 0);
        chk(q, 0);
        // unsolicited message, then a command refused under soft reset
        um <= 1'b1;
        @(posedge clk);
        um <= 1'b0;
        psr <= 1'b1;
        repeat (2) @(posedge clk);
        bus(OFS_CMD, 0, 1);
        bus(OFS_STATUS, 0, 0);
        chk(q & 32'h0821, 32'h0820);
        psr <= 1'b0;
        for (op = 0; op < 4; op++)
        begin
            e = x;
            bus(OFS_ADDR_LO, e, 1);
            bus(OFS_WDATA, ~e, 1);
            bus(OFS_CFG, {28'h0, e[3:0]}, 1);
            bus(OFS_CMD, {22'h0, e[9:8], 6'h0, op[1:0]}, 1);
            k = 0;
            do
            begin
                bus(OFS_STATUS, 0, 0);
                k++;
            end
            while (q[op+1] !== 1'b1 && k < 60);
            chk({31'h0, q[op+1]}, 1);
            if (op == 0)
            begin
                bus(OFS_RDATA, 0, 0);
                chk(q, e);
            end
            bus(OFS_STATUS, 32'h3e, 1);
        end
        bus(OFS_STATUS, 0, 0);
        chk(q & 32'h3ff, 0);
        tally_and_finish;
    end
endmodule // accel_host_memory_port_tb
`default_nettype wire

// *** test/ahm_port_model.sv ***
// port model: answers each request next cycle, tag unchanged
// assumes the client's tx outputs on one shared clock
`timescale 1ns/10ps
`default_nettype none
module ahm_port_model
    import ahm_pkg::*;
(
    // clock, reset, stall, unsolicited message
    input  wire logic               clk_in,
    input  wire logic               srst_in,
    input  wire logic               stall_in,
    input  wire logic               um_in,
    // requests
    input  wire logic               v0_in,
    input  wire logic [ADDR_W-1:0]  a0_in,
    input  wire logic [MDATA_W-1:0] m0_in,
    input  wire logic               v1_in,
    input  wire logic [TYPE_W-1:0]  t1_in,
    input  wire logic [MDATA_W-1:0] m1_in,
    // answers
    output logic                    af_out,
    output logic                    r0v_out,
    output logic      [MDATA_W-1:0] r0m_out,
    output logic      [LINE_W-1:0]  r0d_out,
    output logic      [TYPE_W-1:0]  r0t_out,
    output logic                    r1v_out,
    output logic      [TYPE_W-1:0]  r1t_out,
    output logic      [MDATA_W-1:0] r1m_out
);
    assign af_out = stall_in;
    // idle tag and data lines invert so stale values never look valid
    always_ff @(posedge clk_in)
    begin
        r0v_out <= ~srst_in & (v0_in | um_in);
        r0t_out <= v0_in ? RSP_MEM_READ : RSP_UNSOLICITED;
        r0m_out <= v0_in ? m0_in : ~r0m_out;
        r0d_out <= v0_in ? {16{a0_in[31:0]}} : ~r0d_out;
        r1v_out <= ~srst_in & v1_in;
        r1m_out <= v1_in ? m1_in : ~r1m_out;
        r1t_out <= t1_in == REQ_WRITE_FENCE ? RSP_FENCE :
                   t1_in == REQ_INTR ? RSP_INTR : RSP_MEM_WRITE;
    end
endmodule // ahm_port_model
`default_nettype wire
